// file: core/epw_pkg.sv
// Purpose: shared types of the page-write block
// Assumes: nothing beyond the register header
// Notes:   numbers live in epw_regs.svh
package epw_pkg;

	// ----------------------------------------------------------------
	// protection state held in the status register
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       arm;
		logic [1:0] bp;
		logic       wen;
	} epw_status_t;

	// ----------------------------------------------------------------
	// outcome of the last frame
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		EPW_RES_NONE,
		EPW_RES_DONE,
		EPW_RES_REFUSED,
		EPW_RES_IGNORED
	} epw_result_t;

	// ----------------------------------------------------------------
	// sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		EPW_IDLE,
		EPW_DECIDE,
		EPW_COMMIT,
		EPW_WAIT
	} epw_state_t;

endpackage : epw_pkg

// file: core/epw_regs.svh
// Purpose: register offsets, field positions, op codes and timing for the page-write block
// Assumes: 32-bit APB, one aligned word per register
// Notes:   included by the top module only; the package does not include it
`ifndef EPW_REGS_SVH
`define EPW_REGS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define EPW_OFF_STATUS    12'h000
`define EPW_OFF_CTRL      12'h004
`define EPW_OFF_RADDR     12'h008
`define EPW_OFF_RDATA     12'h00c
`define EPW_OFF_RESULT    12'h010

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define EPW_ST_BUSY       0
`define EPW_ST_WEN        1
`define EPW_ST_BP_LO      2
`define EPW_ST_BP_HI      3
`define EPW_ST_ARM        7
`define EPW_ST_PIN        8
`define EPW_ST_HWACT      9

// ----------------------------------------------------------------
// control register fields and reset value
// ----------------------------------------------------------------
`define EPW_CTRL_EN       0
`define EPW_CTRL_RESET    1'h1

// ----------------------------------------------------------------
// op codes: upper nibble must be zero, bit 3 ignored
// ----------------------------------------------------------------
`define EPW_OP_UPPER      4'h0
`define EPW_OP_WRITE      3'h2
`define EPW_OP_SET_WRITE_LATCH_CMD       3'h6
`define EPW_OP_WRDI       3'h4
`define EPW_OP_WRSR       3'h1
`define EPW_OP_READ_STATE_CMD       3'h5

// ----------------------------------------------------------------
// frame byte positions
// ----------------------------------------------------------------
`define EPW_BYTE_OP       2'h0
`define EPW_BYTE_AHI      2'h1
`define EPW_BYTE_ALO      2'h2
`define EPW_BYTE_DATA     2'h3
`define EPW_MIN_WRITE     3'h4
`define EPW_MIN_WRSR      3'h2
`define EPW_MIN_CMD       3'h1
`define EPW_LAST_BIT      3'h7

// ----------------------------------------------------------------
// array geometry and protection windows
// ----------------------------------------------------------------
`define EPW_PAGE_LAST     5'h1f
`define EPW_ARRAY_WORDS   4096
`define EPW_BP_NONE       2'h0
`define EPW_BP_QUARTER    2'h1
`define EPW_BP_HALF       2'h2
`define EPW_BP_ALL        2'h3
`define EPW_QUARTER_TOP   2'h3

// ----------------------------------------------------------------
// write cycle time
// ----------------------------------------------------------------
`define EPW_WC_TIME_MS    5
`define EPW_PCLK_HZ       10000000
`define EPW_MS_PER_S      1000

`endif

// file: core/epw_top.sv
// Purpose: page write and write protection of a 4096-byte serial eeprom
// Assumes: spi mode 0/3 on sck; apb slave on pclk; cs_n high >= 400 ns between frames
// Notes:   frame bytes are captured on sck and handed over when cs_n rises
`timescale 1ns/1ps
`include "epw_regs.svh"

// Behaviour
// - write is opcode, 16-bit address, data
// - further data bytes go to next address
// - one write touches at most one page
// - offset within page is the five low address bits
// - after last page byte wrap to start
// - excess bytes keep only the final 32
// - block-protected locations are never modified
// - unprotected locations need write latch set
// - array write completion clears write latch
// - hardware protection ignores the array
// - hardware protection needs arm bit and pin low
// - arm and protect bits need latch, no hw-protection
// - only address bits 11 to 0 decoded
// - write opcode is 0000 x010
// - protect bits select none, quarter, half, all
// - busy device ignores every serial frame
module epw_top
	import epw_pkg::*;
#(
	parameter int unsigned WC_CYCLES = `EPW_WC_TIME_MS * (`EPW_PCLK_HZ / `EPW_MS_PER_S)
) (
	// apb clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb request
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	// apb answer
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// serial link
	input  wire logic        sck,
	input  wire logic        cs_n,
	input  wire logic        si,
	input  wire logic        wp_n,
	// status
	output logic             busy
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic op_is(input logic [7:0] op, input logic [2:0] code);
		// bit 3 is a don't care
		return (op[7:4] == `EPW_OP_UPPER) && (op[2:0] == code);
	endfunction : op_is

	function automatic logic prot_hit(input logic [1:0] bp, input logic [11:0] a);
		case (bp)
			`EPW_BP_NONE:    return 1'b0;
			`EPW_BP_QUARTER: return (a[11:10] == `EPW_QUARTER_TOP);
			`EPW_BP_HALF:    return a[11];
			`EPW_BP_ALL:     return 1'b1;
			default:         return 1'b1;
		endcase
	endfunction : prot_hit

	// ----------------------------------------------------------------
	// link domain: byte capture on sck
	// ----------------------------------------------------------------
	logic        link_rst_n;
	logic [2:0]  bit_cnt;
	logic [1:0]  byte_no;
	logic [4:0]  dptr;
	logic [6:0]  shreg;
	logic [7:0]  shifted;
	logic        byte_done;
	logic        frame_first;
	logic        l_fresh;
	logic [7:0]  l_op;
	logic [15:0] l_addr;
	logic [31:0] l_mask;
	logic [2:0]  l_bytes;
	logic        l_aligned;
	logic [7:0]  l_buf [0:31];

	// chip select high holds the frame counters in reset
	assign link_rst_n  = presetn & ~cs_n;
	assign shifted     = {shreg, si};
	assign byte_done   = (bit_cnt == `EPW_LAST_BIT);
	assign frame_first = (bit_cnt == 3'h0) && (byte_no == `EPW_BYTE_OP) && !l_fresh;

	always_ff @(posedge sck or negedge link_rst_n) begin
		if (!link_rst_n) begin
			bit_cnt <= 3'h0;
			byte_no <= `EPW_BYTE_OP;
			shreg   <= 7'h00;
			l_fresh <= 1'b0;
		end else begin
			bit_cnt <= bit_cnt + 3'h1;
			shreg   <= shifted[6:0];
			l_fresh <= 1'b1;
			if (byte_done && (byte_no != `EPW_BYTE_DATA)) begin
				byte_no <= byte_no + 2'h1;
			end
		end
	end

	// header bytes and alignment; kept through cs_n high for the hand-over
	always_ff @(posedge sck or negedge presetn) begin
		if (!presetn) begin
			l_op      <= 8'h00;
			l_addr    <= 16'h0000;
			l_bytes   <= 3'h0;
			l_aligned <= 1'b0;
		end else begin
			l_aligned <= byte_done;
			if (frame_first) begin
				l_bytes <= 3'h0;
			end else if (byte_done && (l_bytes != `EPW_MIN_WRITE)) begin
				l_bytes <= l_bytes + 3'h1;
			end
			if (byte_done) begin
				case (byte_no)
					`EPW_BYTE_OP:  l_op          <= shifted;
					`EPW_BYTE_AHI: l_addr[15:8]  <= shifted;
					`EPW_BYTE_ALO: l_addr[7:0]   <= shifted;
					default:       l_op          <= l_op;
				endcase
			end
		end
	end

	// data bytes into the page buffer
	always_ff @(posedge sck or negedge presetn) begin
		if (!presetn) begin
			dptr   <= 5'h00;
			l_mask <= 32'h0000_0000;
		end else begin
			if (byte_done && (byte_no == `EPW_BYTE_ALO)) begin
				dptr <= shifted[4:0];
			end else if (byte_done && (byte_no == `EPW_BYTE_DATA)) begin
				dptr <= dptr + 5'h01;
			end
			if (frame_first) begin
				l_mask <= 32'h0000_0000;
			end else if (byte_done && (byte_no == `EPW_BYTE_DATA)) begin
				l_mask[dptr] <= 1'b1;
			end
		end
	end

	always_ff @(posedge sck) begin
		if (byte_done && (byte_no == `EPW_BYTE_DATA)) begin
			l_buf[dptr] <= shifted;
		end
	end

	// ----------------------------------------------------------------
	// crossing into pclk
	// ----------------------------------------------------------------
	logic [2:0] cs_sync;
	logic [1:0] wp_sync;
	logic       cs_rise;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cs_sync <= 3'h7;
			wp_sync <= 2'h3;
		end else begin
			cs_sync <= {cs_sync[1:0], cs_n};
			wp_sync <= {wp_sync[0], wp_n};
		end
	end

	// rising chip select ends the frame
	assign cs_rise = cs_sync[1] && !cs_sync[2];

	// snapshot of the frame, stable while cs_n stays high
	logic [7:0]  p_op;
	logic [7:0]  p_sr;
	logic [11:0] p_addr;
	logic [31:0] p_mask;
	logic [2:0]  p_bytes;
	logic        p_aligned;
	logic [7:0]  p_buf [0:31];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			p_op      <= 8'h00;
			p_sr      <= 8'h00;
			p_addr    <= 12'h000;
			p_mask    <= 32'h0000_0000;
			p_bytes   <= 3'h0;
			p_aligned <= 1'b0;
		end else if (cs_rise && !busy) begin
			p_op      <= l_op;
			p_sr      <= l_addr[15:8];
			p_addr    <= l_addr[11:0];
			p_mask    <= l_mask;
			p_bytes   <= l_bytes;
			p_aligned <= l_aligned;
		end
	end

	always_ff @(posedge pclk) begin
		if (cs_rise && !busy) begin
			p_buf <= l_buf;
		end
	end

	// ----------------------------------------------------------------
	// protection and sequencing
	// ----------------------------------------------------------------
	epw_state_t  state;
	epw_status_t stat;
	epw_result_t result;
	logic        hw_active;
	logic        ctrl_en;
	logic        wrsr_pend;
	logic [4:0]  cidx;
	logic [31:0] wc_cnt;

	assign hw_active = stat.arm && !wp_sync[1];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state     <= EPW_IDLE;
			stat      <= '0;
			result    <= EPW_RES_NONE;
			busy      <= 1'b0;
			wrsr_pend <= 1'b0;
			cidx      <= 5'h00;
			wc_cnt    <= 32'h0000_0000;
		end else begin
			case (state)
				EPW_IDLE: begin
					if (cs_rise) begin
						state <= EPW_DECIDE;
					end
				end
				EPW_DECIDE: begin
					state <= EPW_IDLE;
					if (!ctrl_en || !p_aligned || (p_bytes < `EPW_MIN_CMD)) begin
						result <= EPW_RES_IGNORED;
					end else if (op_is(p_op, `EPW_OP_WRITE) && (p_bytes >= `EPW_MIN_WRITE)) begin
						if (stat.wen && !prot_hit(stat.bp, p_addr)) begin
							state  <= EPW_COMMIT;
							busy   <= 1'b1;
							cidx   <= 5'h00;
							wc_cnt <= 32'h0000_0000;
						end else begin
							result <= EPW_RES_REFUSED;
						end
					end else if (op_is(p_op, `EPW_OP_WRSR) && (p_bytes >= `EPW_MIN_WRSR)) begin
						// status bits need latch and no hw protection
						if (stat.wen && !hw_active) begin
							state     <= EPW_WAIT;
							busy      <= 1'b1;
							wrsr_pend <= 1'b1;
							wc_cnt    <= 32'h0000_0000;
						end else begin
							result <= EPW_RES_REFUSED;
						end
					end else if (op_is(p_op, `EPW_OP_SET_WRITE_LATCH_CMD)) begin
						stat.wen <= 1'b1;
						result   <= EPW_RES_DONE;
					end else if (op_is(p_op, `EPW_OP_WRDI)) begin
						stat.wen <= 1'b0;
						result   <= EPW_RES_DONE;
					end else begin
						result <= EPW_RES_IGNORED;
					end
				end
				EPW_COMMIT: begin
					// only the 32 slots of one page
					cidx   <= cidx + 5'h01;
					wc_cnt <= wc_cnt + 32'h0000_0001;
					if (cidx == `EPW_PAGE_LAST) begin
						state <= EPW_WAIT;
					end
				end
				EPW_WAIT: begin
					wc_cnt <= wc_cnt + 32'h0000_0001;
					if (wc_cnt >= 32'(WC_CYCLES - 1)) begin
						state     <= EPW_IDLE;
						busy      <= 1'b0;
						result    <= EPW_RES_DONE;
						stat.wen  <= 1'b0;
						wrsr_pend <= 1'b0;
						if (wrsr_pend) begin
							stat.arm <= p_sr[`EPW_ST_ARM];
							stat.bp  <= {p_sr[`EPW_ST_BP_HI], p_sr[`EPW_ST_BP_LO]};
						end
					end
				end
				default: state <= EPW_IDLE;
			endcase
			// frames during a cycle are dropped
			if (busy && cs_rise) begin
				result <= EPW_RES_IGNORED;
			end
		end
	end

	// ----------------------------------------------------------------
	// array
	// ----------------------------------------------------------------
	logic [7:0] mem [0:`EPW_ARRAY_WORDS-1];

	always_ff @(posedge pclk) begin
		if ((state == EPW_COMMIT) && p_mask[cidx]) begin
			mem[{p_addr[11:5], cidx}] <= p_buf[cidx];
		end
	end

	// ----------------------------------------------------------------
	// apb slave: one wait-free access phase
	// ----------------------------------------------------------------
	logic        setup;
	logic        wr_acc;
	logic [11:0] raddr;
	logic [31:0] st_word;
	logic        mapped;

	assign setup  = psel && !penable;
	assign wr_acc = psel && penable && pready && pwrite;
	assign mapped = (paddr == `EPW_OFF_STATUS) || (paddr == `EPW_OFF_CTRL)
		|| (paddr == `EPW_OFF_RADDR) || (paddr == `EPW_OFF_RDATA)
		|| (paddr == `EPW_OFF_RESULT);

	always_comb begin
		st_word                = 32'h0000_0000;
		st_word[`EPW_ST_BUSY]  = busy;
		st_word[`EPW_ST_WEN]   = stat.wen;
		st_word[`EPW_ST_BP_LO] = stat.bp[0];
		st_word[`EPW_ST_BP_HI] = stat.bp[1];
		st_word[`EPW_ST_ARM]   = stat.arm;
		st_word[`EPW_ST_PIN]   = wp_sync[1];
		st_word[`EPW_ST_HWACT] = hw_active;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= setup;
			pslverr <= setup && !mapped;
			prdata  <= 32'h0000_0000;
			if (setup && !pwrite) begin
				case (paddr)
					`EPW_OFF_STATUS: prdata <= st_word;
					`EPW_OFF_CTRL:   prdata <= {31'h0, ctrl_en};
					`EPW_OFF_RADDR:  prdata <= {20'h0, raddr};
					`EPW_OFF_RDATA:  prdata <= {24'h0, mem[raddr]};
					`EPW_OFF_RESULT: prdata <= {30'h0, result};
					default:         prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_en <= `EPW_CTRL_RESET;
			raddr   <= 12'h000;
		end else if (wr_acc) begin
			if (paddr == `EPW_OFF_CTRL)
				ctrl_en <= pwdata[`EPW_CTRL_EN];
			if (paddr == `EPW_OFF_RADDR)
				raddr <= pwdata[11:0];
		end
	end

endmodule : epw_top

// file: dv/epw_host_model.sv
// Purpose: serial host that frames bytes toward the page-write block
// Assumes: mode 0, 32 ns link clock that only runs inside frames
// Notes:   data line shows the inverse of its last bit between frames
`timescale 1ns/1ps
module epw_host_model (
	// serial link toward the device
	output logic sck,
	output logic cs_n,
	output logic si
);
	localparam time HALF = 16;

	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b1;
	end

	// ----
	// one frame of n bytes, then the idle gap
	// ----
	task send(input logic [7:0] fb [0:39], input int n);
		int b;
		#3;
		cs_n = 1'b0;
		#HALF;
		for (b = 0; b < n * 8; b++) begin
			si = fb[b / 8][7 - b % 8];
			#HALF;
			sck = 1'b1;
			#HALF;
			sck = 1'b0;
		end
		#HALF;
		// chip select rises before any further edge
		cs_n = 1'b1;
		si = ~si;
		#500;
	endtask : send
endmodule : epw_host_model

// file: dv/epw_top_monitor.sv
// Purpose: port checker for the page-write block
// Assumes: WC_CYCLES equals the bound instance's value
// Notes:   bound into every epw_top
`timescale 1ns/1ps
module epw_top_monitor #(
	parameter int unsigned WC_CYCLES = 64
) (
	// apb
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic [11:0] paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// link and status
	input wire logic        sck,
	input wire logic        cs_n,
	input wire logic        si,
	input wire logic        wp_n,
	input wire logic        busy
);
	int unsigned busy_cnt;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_cnt <= 0;
		end else begin
			busy_cnt <= busy ? busy_cnt + 1 : 0;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_ready_in_access: assert property (pready |-> psel && penable)
		else $error("ready outside access");
	a_err_unmapped: assert property (pready && paddr > 12'h010 |-> pslverr)
		else $error("unmapped access without error");
	a_ok_mapped: assert property (pready && paddr inside {12'h000, 12'h004,
		12'h008, 12'h00c, 12'h010} |-> !pslverr)
		else $error("error on mapped access");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside access");
	a_hw_active: assert property (
		pready && !pwrite && paddr == 12'h000 |-> prdata[9] == (prdata[7] && !prdata[8]))
		else $error("hardware protect flag wrong");
	a_status_reserved: assert property (pready && !pwrite && paddr == 12'h000
		|-> prdata[31:10] == 22'h0 && prdata[6:4] == 3'h0)
		else $error("reserved status bits set");
	a_busy_length: assert property (busy |-> busy_cnt < WC_CYCLES)
		else $error("write cycle too long");
	a_busy_full: assert property ($fell(busy) |-> busy_cnt == WC_CYCLES)
		else $error("write cycle cut short");
	a_busy_after_frame: assert property ($rose(busy) |-> cs_n && $past(cs_n, 2))
		else $error("write cycle without closed frame");
endmodule : epw_top_monitor

bind epw_top epw_top_monitor #(.WC_CYCLES(WC_CYCLES)) i_epw_top_monitor (
	.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
	.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n), .busy(busy));

// file: dv/epw_top_tb.sv
// Purpose: self-checking bench of the page-write block
// Assumes: short write cycle of 64 pclk
// Notes:   array content is seen through the read address port
`timescale 1ns/1ps
module epw_top_tb;
	import epw_pkg::*;
	localparam int WC = 64;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        sck, cs_n, si, wp_n, busy, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q, nb;
	logic [7:0]  fb [0:39];
	logic [7:0]  ex [0:31];
	int          lim [4] = '{4096, 3072, 2048, 0};
	int          mismatches, checks, i, k, a;

	epw_top #(.WC_CYCLES(WC)) i_epw_top (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n), .busy(busy));
	epw_host_model i_epw_host_model (.sck(sck), .cs_n(cs_n), .si(si));

	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	// ----
	// access tasks
	// ----
	task chk(input logic [31:0] g, input logic [31:0] x);
		checks++;
		if (g !== x) begin
			mismatches++;
			$display("BAD %0t got %h expected %h", $time, g, x);
		end
	endtask : chk

	task apb(input logic [11:0] ad, input logic w, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= ad;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		for (n = 0; n < 20 && pready !== 1'b1; n++)
			@(posedge pclk);
		chk({31'h0, pready}, 32'h1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task rd(input logic [11:0] ad, input logic [31:0] x);
		apb(ad, 1'b0, 32'h0);
		chk(q, x);
	endtask : rd

	task peek(input int ad);
		apb(12'h008, 1'b1, 32'(ad));
		apb(12'h00c, 1'b0, 32'h0);
	endtask : peek

	task settle;
		int j;
		repeat (8) @(posedge pclk);
		for (j = 0; j < 300 && busy !== 1'b0; j++)
			@(posedge pclk);
		chk({31'h0, busy}, 32'h0);
	endtask : settle

	task frame(input int n);
		i_epw_host_model.send(fb, n);
		settle();
	endtask : frame

	task op(input logic [7:0] b);
		fb[0] = b;
		frame(1);
	endtask : op

	task wr(input logic [7:0] o, input logic [15:0] ad, input int n);
		fb[0] = o;
		fb[1] = ad[15:8];
		fb[2] = ad[7:0];
		frame(n + 3);
	endtask : wr

	task wrsr(input logic [7:0] s);
		fb[0] = 8'h01;
		fb[1] = s;
		frame(2);
	endtask : wrsr

	task stop_test;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : stop_test

	initial begin
		#2000000;
		mismatches++;
		stop_test();
	end

	// ----
	// main sequence
	// ----
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		wp_n = 1'b1;
		mismatches = 0;
		checks = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		rd(12'h000, 32'h100);
		rd(12'h004, 32'h1);
		rd(12'h008, 32'h0);
		rd(12'h010, 32'h0);
		rd(12'h020, 32'h0);
		chk({31'h0, e}, 32'h1);
		peek(0);
		nb = q;
		fb[3] = 8'h5a;
		wr(8'h02, 16'h0000, 1);
		rd(12'h010, 32'h2);
		peek(0);
		chk(q, nb);
		peek(12'h400);
		nb = q;
		op(8'h06);
		for (i = 0; i < 35; i++) begin
			fb[3 + i] = 8'(i + 1);
			ex[(30 + i) % 32] = 8'(i + 1);
		end
		wr(8'h0a, 16'hf3fe, 35);
		rd(12'h010, 32'h1);
		rd(12'h000, 32'h100);
		for (i = 0; i < 32; i++) begin
			peek(12'h3e0 + i);
			chk(q, {24'h0, ex[i]});
		end
		peek(12'h400);
		chk(q, nb);
		op(8'h06);
		wrsr(8'h84);
		rd(12'h000, 32'h184);
		@(posedge pclk);
		wp_n <= 1'b0;
		repeat (4) @(posedge pclk);
		rd(12'h000, 32'h284);
		op(8'h06);
		fb[3] = 8'h33;
		wr(8'h02, 16'h0000, 1);
		rd(12'h010, 32'h1);
		peek(0);
		chk(q, 32'h33);
		op(8'h06);
		wr(8'h02, 16'h0c00, 1);
		rd(12'h010, 32'h2);
		wrsr(8'h00);
		rd(12'h010, 32'h2);
		rd(12'h000, 32'h286);
		@(posedge pclk);
		wp_n <= 1'b1;
		repeat (4) @(posedge pclk);
		wrsr(8'h00);
		rd(12'h010, 32'h1);
		for (i = 0; i < 4; i++) begin
			op(8'h06);
			wrsr(8'(i << 2));
			for (k = 0; k < 2; k++) begin
				a = (lim[i] - 32 + 32 * k) & 12'hfff;
				op(8'h06);
				wr(8'h02, 16'(a), 1);
				rd(12'h010, (a >= lim[i]) ? 32'h2 : 32'h1);
			end
		end
		op(8'h06);
		wrsr(8'h00);
		op(8'h06);
		fb[0] = 8'h02;
		fb[1] = 8'h00;
		fb[2] = 8'h40;
		i_epw_host_model.send(fb, 4);
		for (k = 0; k < 20 && busy !== 1'b1; k++)
			@(posedge pclk);
		fb[0] = 8'h04;
		i_epw_host_model.send(fb, 1);
		rd(12'h010, 32'h3);
		chk({31'h0, busy}, 32'h1);
		settle();
		apb(12'h004, 1'b1, 32'h0);
		op(8'h06);
		rd(12'h010, 32'h3);
		rd(12'h000, 32'h100);
		apb(12'h004, 1'b1, 32'h1);
		op(8'h06);
		fb[0] = 8'h02;
		frame(3);
		rd(12'h010, 32'h3);
		rd(12'h000, 32'h102);
		stop_test();
	end
endmodule : epw_top_tb
